// ### rtl/plb_pkg.sv
`default_nettype none
package plb_pkg;
	// ----------------------------------------------------------------
	// device shape
	// ----------------------------------------------------------------
	localparam int NUM_BLK   = 4;   // logic blocks
	localparam int NUM_PIO   = 32;  // two-way pins
	localparam int NUM_DIN   = 4;   // dedicated inputs
	localparam int NUM_CKP   = 2;   // clock_or_input_pin count
	localparam int NUM_SEL   = 22;  // routed signals into each block
	localparam int NUM_LTERM = 64;  // logic product terms per block
	localparam int NUM_SPT   = 4;   // special product terms per block
	localparam int NUM_PT    = NUM_LTERM + NUM_SPT;
	localparam int NUM_MC    = 16;  // macrocells per block
	localparam int NUM_OMC   = 8;   // output macrocells / pins per block
	localparam int CLU_TERMS = 4;   // terms per cluster
	localparam int NUM_CLU   = NUM_LTERM / CLU_TERMS;
	localparam int CLU_SPAN  = 4;   // clusters reachable by one macrocell
	localparam int NUM_LVL   = NUM_DIN + NUM_CKP + NUM_PIO;
	localparam int LVL_CKP   = NUM_DIN;            // first clock pin level
	localparam int LVL_PIO   = NUM_DIN + NUM_CKP;  // first pin level
	localparam int NUM_SRC   = NUM_LVL + NUM_BLK * NUM_MC;
	localparam int SRC_W     = 7;
	// special term indices
	localparam int PT_OE0  = 64;
	localparam int PT_OE1  = 65;
	localparam int PT_ARST = 66;
	localparam int PT_APRE = 67;
	// ----------------------------------------------------------------
	// register map (word index fields of the byte address)
	// ----------------------------------------------------------------
	localparam int ADR_W = 14;
	localparam logic [1:0] REG_TERM  = 2'h0;
	localparam logic [1:0] REG_ROUTE = 2'h1;
	localparam logic [1:0] REG_MCELL = 2'h2;
	localparam logic [1:0] REG_GLOB  = 2'h3;
	localparam logic [7:0] GLB_CTRL  = 8'h00;
	localparam logic [7:0] GLB_STAT  = 8'h01;
	localparam int CTRL_RUN_BIT = 0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// macrocell configuration word
	localparam int MC_W        = 11;
	localparam int MC_MODE_LSB = 0;
	localparam int MC_POL_BIT  = 2;
	localparam int MC_TFF_BIT  = 3;
	localparam int MC_CKS_BIT  = 4;
	localparam int MC_CLU_LSB  = 5;
	localparam int MC_OE_LSB   = 9;
	localparam logic [1:0] MODE_COMB  = 2'h0;
	localparam logic [1:0] MODE_REG   = 2'h1;
	localparam logic [1:0] MODE_LATCH = 2'h2;
	localparam logic [1:0] MODE_INPUT = 2'h3;
	localparam logic [1:0] OE_OFF = 2'h0;
	localparam logic [1:0] OE_ON  = 2'h1;
	localparam logic [1:0] OE_PT0 = 2'h2;
	localparam logic [1:0] OE_PT1 = 2'h3;
endpackage : plb_pkg
`default_nettype wire

// ### rtl/plb_macrocell.sv
`timescale 1ns/1ps
`default_nettype none
module plb_macrocell #(
	parameter bit BURIED = 1'b0
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// configuration
	input  wire logic       run_i,
	input  wire logic [1:0] mode_i,
	input  wire logic       pol_i,
	input  wire logic       tff_i,
	input  wire logic       cks_i,
	// logic inputs
	input  wire logic       sum_i,
	input  wire logic [1:0] rise_i,
	input  wire logic [1:0] gate_i,
	input  wire logic       pin_i,
	input  wire logic       arst_i,
	input  wire logic       apre_i,
	// feedback and pin data
	output logic            fb_o
);
	import plb_pkg::*;

	logic st_q, st_d;
	logic out_q, out_d;
	logic upd, dat, store;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// comb mode is registered at clk too, which breaks feedback loops
	always_comb begin
		upd   = 1'b1;
		dat   = sum_i;
		store = 1'b0;
		case (mode_i)
			MODE_REG: begin
				store = 1'b1;
				upd   = rise_i[cks_i];                // RULE10 RULE11
				dat   = tff_i ? (st_q ^ sum_i) : sum_i; // RULE8
			end
			MODE_LATCH: begin
				store = 1'b1;
				upd   = ~gate_i[cks_i];                 // RULE12
			end
			MODE_INPUT: begin
				// input storage exists only on buried cells
				store = BURIED;
				dat   = BURIED ? pin_i : sum_i;         // RULE14
				upd   = !BURIED ? 1'b1 :
					(tff_i ? ~gate_i[cks_i] : rise_i[cks_i]);
			end
			default: begin
				upd = 1'b1;                             // RULE7
			end
		endcase
		if (!run_i) begin
			st_d = 1'b0;
		end else if (store && arst_i) begin
			st_d = 1'b0;                                // RULE13 RULE20
		end else if (store && apre_i) begin
			st_d = 1'b1;                                // RULE13
		end else if (upd) begin
			st_d = dat;
		end else begin
			st_d = st_q;
		end
		out_d = st_d ^ pol_i;                           // RULE7
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q  <= 1'b0;
			out_q <= 1'b0;
		end else begin
			st_q  <= st_d;
			out_q <= out_d;
		end
	end

	assign fb_o = out_q; // RULE9
endmodule : plb_macrocell
`default_nettype wire

// ### rtl/plb_top.sv
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: four blocks, 32 two-way, 4 inputs, 2 clock pins
// RULE2: routing delivers 22 chosen signals per block
// RULE3: 64 terms, allocator, 8+8 macrocells, 8 pins
// RULE4: block returns 16 macrocell, 8 pin feedbacks
// RULE5: four special terms: two enables, reset, preset
// RULE6: allocator gives each macrocell up to 16 terms; here cells 0 and 14 reach only 12 and cell 15 only 8
// RULE7: output cell: register, latch or comb, polarity
// RULE8: register may be D or toggle type
// RULE9: every macrocell always feeds back to routing
// RULE10: each storage picks one clock pin; pins stay inputs
// RULE11: register captures on selected clock rising edge
// RULE12: latch transparent gate low, holds gate high
// RULE13: block reset and preset hit all storage, unclocked; here they take effect at the next clk_i edge
// RULE14: buried cell: full function or input storage
// RULE15: internally used output frees its pin as input
// RULE16: pin driver: always on, always off, term
// RULE17: term control picks one of two shared terms
// RULE18: keepers hold undriven inputs at last level
// RULE19: configuration static, loaded before running
// RULE20: reset beats preset, storage goes to zero
module plb_top (
	// clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	// wishbone slave
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [plb_pkg::ADR_W-1:0]     wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic      [31:0]                   wb_dat_o,
	output logic                               wb_ack_o,
	// dedicated and clock_or_input_pin inputs, with board drive flags
	input  wire logic [plb_pkg::NUM_DIN-1:0]   din_i,
	input  wire logic [plb_pkg::NUM_DIN-1:0]   din_drv_i,
	input  wire logic [plb_pkg::NUM_CKP-1:0]   clock_or_input_pin_i,
	input  wire logic [plb_pkg::NUM_CKP-1:0]   clock_or_input_pin_drv_i,
	// two-way pins
	input  wire logic [plb_pkg::NUM_PIO-1:0]   pio_i,
	input  wire logic [plb_pkg::NUM_PIO-1:0]   pio_drv_i,
	output logic      [plb_pkg::NUM_PIO-1:0]   pio_o,
	output logic      [plb_pkg::NUM_PIO-1:0]   pio_oe_o
);
	import plb_pkg::*;

	// ----------------------------------------------------------------
	// configuration store
	// ----------------------------------------------------------------
	logic [31:0]        ctrl_q, ctrl_d;
	logic [NUM_SEL-1:0] tmask_q [NUM_BLK][NUM_PT];
	logic [NUM_SEL-1:0] cmask_q [NUM_BLK][NUM_PT];
	logic [SRC_W-1:0]   route_q [NUM_BLK][NUM_SEL];
	logic [MC_W-1:0]    mcfg_q  [NUM_BLK][NUM_MC];
	logic [NUM_SEL-1:0] tmask_d [NUM_BLK][NUM_PT];
	logic [NUM_SEL-1:0] cmask_d [NUM_BLK][NUM_PT];
	logic [SRC_W-1:0]   route_d [NUM_BLK][NUM_SEL];
	logic [MC_W-1:0]    mcfg_d  [NUM_BLK][NUM_MC];
	logic               run;

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic        ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic        req, hit, wr_cfg;
	logic [31:0] cur, wdat;
	logic [1:0]  a_blk, a_reg;
	logic [7:0]  a_idx;

	// ----------------------------------------------------------------
	// pin levels, clock pin edges, feedback
	// ----------------------------------------------------------------
	logic [NUM_LVL-1:0]        lvl_q, lvl_d;
	logic [NUM_LVL-1:0]        ext_all, drv_all, own_all, own_oe_all;
	logic [NUM_CKP-1:0]        ckp_prev_q;
	logic [NUM_CKP-1:0]        ckp_rise, ckp_gate;
	logic [NUM_BLK*NUM_MC-1:0] mc_fb;
	logic [NUM_SRC-1:0]        src;
	logic [NUM_PIO-1:0]        pio_oe_q, pio_oe_d;

	// a request is taken once; the ack flop masks it in its answer cycle
	assign run   = ctrl_q[CTRL_RUN_BIT];
	assign a_blk = wb_adr_i[13:12];
	assign a_reg = wb_adr_i[11:10];
	assign a_idx = wb_adr_i[9:2];
	assign req   = wb_cyc_i & wb_stb_i & ~ack_q;

	// byte-lane merge so partial writes keep the untouched lanes
	function automatic logic [31:0] plb_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			plb_merge[i*8 +: 8] = sel[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
		end
	endfunction : plb_merge

	// decode, read mux and write control
	always_comb begin
		cur    = 32'h0;
		hit    = 1'b0;
		ctrl_d = ctrl_q;
		case (a_reg)
			REG_TERM: begin
				if (a_idx < 8'(2 * NUM_PT)) begin
					hit = 1'b1;
					cur = a_idx[0] ? 32'(cmask_q[a_blk][a_idx[7:1]])
						: 32'(tmask_q[a_blk][a_idx[7:1]]);
				end
			end
			REG_ROUTE: begin
				if (a_idx < 8'(NUM_SEL)) begin
					hit = 1'b1;
					cur = 32'(route_q[a_blk][a_idx[4:0]]);
				end
			end
			REG_MCELL: begin
				if (a_idx < 8'(NUM_MC)) begin
					hit = 1'b1;
					cur = 32'(mcfg_q[a_blk][a_idx[3:0]]);
				end
			end
			default: begin
				if (a_idx == GLB_CTRL) begin
					cur = ctrl_q;
				end else if (a_idx == GLB_STAT) begin
					// live state of the addressed block
					cur = {8'h00, lvl_q[LVL_PIO + a_blk*NUM_OMC +: NUM_OMC],
						mc_fb[a_blk*NUM_MC +: NUM_MC]};
				end
			end
		endcase
		wdat   = plb_merge(cur, wb_dat_i, wb_sel_i);
		// config writes are dropped while running: the array must not
		// change under live logic
		wr_cfg = req & wb_we_i & hit & ~run; // RULE19
		if (req && wb_we_i && a_reg == REG_GLOB && a_idx == GLB_CTRL) begin
			ctrl_d = wdat;
		end
		ack_d  = req;
		rdat_d = (req && !wb_we_i) ? cur : 32'h0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0;
			ctrl_q <= CTRL_RST;
		end else begin
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
			ctrl_q <= ctrl_d;
		end
	end

	// next configuration words; writes land only while stopped
	always_comb begin
		tmask_d = tmask_q;
		cmask_d = cmask_q;
		route_d = route_q;
		mcfg_d  = mcfg_q;
		if (wr_cfg) begin
			case (a_reg)
				REG_TERM: begin
					if (a_idx[0]) begin
						cmask_d[a_blk][a_idx[7:1]] = wdat[NUM_SEL-1:0];
					end else begin
						tmask_d[a_blk][a_idx[7:1]] = wdat[NUM_SEL-1:0];
					end
				end
				REG_ROUTE: begin
					route_d[a_blk][a_idx[4:0]] = wdat[SRC_W-1:0];
				end
				REG_MCELL: begin
					mcfg_d[a_blk][a_idx[3:0]] = wdat[MC_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// configuration arrays: cleared by reset, else only registered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int b = 0; b < NUM_BLK; b++) begin
				for (int t = 0; t < NUM_PT; t++) begin
					tmask_q[b][t] <= '0;
					cmask_q[b][t] <= '0;
				end
				for (int s = 0; s < NUM_SEL; s++) begin
					route_q[b][s] <= '0;
				end
				for (int m = 0; m < NUM_MC; m++) begin
					mcfg_q[b][m] <= '0;
				end
			end
		end else begin
			tmask_q <= tmask_d;
			cmask_q <= cmask_d;
			route_q <= route_d;
			mcfg_q  <= mcfg_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ----------------------------------------------------------------
	// keepers on every input and two-way pin
	// ----------------------------------------------------------------
	assign ext_all    = {pio_i, clock_or_input_pin_i, din_i};
	assign drv_all    = {pio_drv_i, clock_or_input_pin_drv_i, din_drv_i};
	assign own_all    = {pio_o, {(NUM_DIN + NUM_CKP){1'b0}}};
	assign own_oe_all = {pio_oe_q, {(NUM_DIN + NUM_CKP){1'b0}}};

	// own driver first, then the board, else the last level is kept
	// the drive flags stand in for a pin that is really driven
	always_comb begin
		for (int i = 0; i < NUM_LVL; i++) begin
			if (own_oe_all[i]) begin
				lvl_d[i] = own_all[i];
			end else if (drv_all[i]) begin
				lvl_d[i] = ext_all[i]; // RULE15
			end else begin
				lvl_d[i] = lvl_q[i];   // RULE18
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lvl_q      <= '0;
			ckp_prev_q <= '0;
		end else begin
			lvl_q      <= lvl_d;
			ckp_prev_q <= lvl_q[LVL_CKP +: NUM_CKP];
		end
	end

	// clock pins are sampled at clk, so edges are one clk late
	assign ckp_gate = lvl_q[LVL_CKP +: NUM_CKP];
	assign ckp_rise = ckp_gate & ~ckp_prev_q; // RULE11

	// routing sources: pins (clock pins included) then all feedbacks
	assign src = {mc_fb, lvl_q}; // RULE1 RULE4 RULE10

	// ----------------------------------------------------------------
	// logic blocks
	// ----------------------------------------------------------------
	for (genvar b = 0; b < NUM_BLK; b++) begin : g_blk
		logic [NUM_SEL-1:0] sel_in;
		logic [NUM_PT-1:0]  pt;
		logic [NUM_MC-1:0]  sum;
		logic [NUM_MC-1:0]  fb;

		// routing matrix into this block
		// an out-of-range source index reads as a constant low
		always_comb begin
			for (int s = 0; s < NUM_SEL; s++) begin
				sel_in[s] = (route_q[b][s] < SRC_W'(NUM_SRC))
					? src[route_q[b][s]] : 1'b0; // RULE2
			end
		end

		// and array; an empty term reads as true
		always_comb begin
			for (int t = 0; t < NUM_PT; t++) begin
				pt[t] = &((~tmask_q[b][t] | sel_in)
					& (~cmask_q[b][t] | ~sel_in)); // RULE3 RULE5
			end
		end

		// allocator: cell m reaches clusters m-1 .. m+2
		// clusters are shared: two cells may sum the same terms
		always_comb begin
			for (int m = 0; m < NUM_MC; m++) begin
				sum[m] = 1'b0;
				for (int k = 0; k < CLU_SPAN; k++) begin
					if (m - 1 + k >= 0 && m - 1 + k < NUM_CLU
						&& mcfg_q[b][m][MC_CLU_LSB + k]) begin
						sum[m] = sum[m]
							| (|pt[(m - 1 + k)*CLU_TERMS +: CLU_TERMS]); // RULE6
					end
				end
			end
		end

		// odd cells are buried: no pin, but they may sample it
		for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
			plb_macrocell #(
				.BURIED (m % 2 == 1)
			) u_mc (
				.clk_i  (clk_i),
				.rst_i  (rst_i),
				.run_i  (run),
				.mode_i (mcfg_q[b][m][MC_MODE_LSB +: 2]),
				.pol_i  (mcfg_q[b][m][MC_POL_BIT]),
				.tff_i  (mcfg_q[b][m][MC_TFF_BIT]),
				.cks_i  (mcfg_q[b][m][MC_CKS_BIT]),
				.sum_i  (sum[m]),
				.rise_i (ckp_rise),
				.gate_i (ckp_gate),
				.pin_i  (lvl_q[LVL_PIO + b*NUM_OMC + m/2]),
				.arst_i (pt[PT_ARST]),
				.apre_i (pt[PT_APRE]),
				.fb_o   (fb[m])
			);
		end

		assign mc_fb[b*NUM_MC +: NUM_MC] = fb; // RULE4 RULE9

		// pin cells fed by the even (output) macrocells
		for (genvar k = 0; k < NUM_OMC; k++) begin : g_pin
			logic [1:0] oe_mode;
			assign oe_mode = mcfg_q[b][2*k][MC_OE_LSB +: 2];
			assign pio_o[b*NUM_OMC + k] = fb[2*k];
			always_comb begin
				case (oe_mode)
					OE_ON:   pio_oe_d[b*NUM_OMC + k] = run;            // RULE16
					OE_PT0:  pio_oe_d[b*NUM_OMC + k] = run & pt[PT_OE0]; // RULE17
					OE_PT1:  pio_oe_d[b*NUM_OMC + k] = run & pt[PT_OE1]; // RULE17
					default: pio_oe_d[b*NUM_OMC + k] = 1'b0;           // RULE16
				endcase
			end
		end
	end

	// enables registered so the pin sees flop outputs only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pio_oe_q <= '0;
		end else begin
			pio_oe_q <= pio_oe_d;
		end
	end

	assign pio_oe_o = pio_oe_q;
endmodule : plb_top
`default_nettype wire

// ### testbench/plb_board.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// board model on the two-way pins
// ------------------------------
module plb_board (
	// clock
	input  wire logic        clk_i,
	// what the board wants to drive
	input  wire logic [31:0] want_i,
	input  wire logic [31:0] want_drv_i,
	// device side of the pins
	input  wire logic [31:0] dev_i,
	input  wire logic [31:0] dev_oe_i,
	// resolved wire and board drive flags
	output logic      [31:0] lvl_o,
	output logic      [31:0] drv_o
);
	logic [31:0] junk_q = 32'h0;
	// the board backs off wherever the device drives, never a fight
	assign drv_o = want_drv_i & ~dev_oe_i;
	// a floating line wanders, so no stale value can pass for a keeper
	always @(posedge clk_i) begin
		junk_q <= ~junk_q;
	end
	// wire level from both parties' enables
	assign lvl_o = (dev_oe_i & dev_i) | (drv_o & want_i)
		| (~dev_oe_i & ~drv_o & junk_q);
endmodule : plb_board
`default_nettype wire

// ### testbench/plb_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module plb_top_sva (
	// clock and reset
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	// wishbone
	input wire logic                      wb_cyc_i,
	input wire logic                      wb_stb_i,
	input wire logic                      wb_we_i,
	input wire logic [plb_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0]                wb_sel_i,
	input wire logic [31:0]               wb_dat_i,
	input wire logic [31:0]               wb_dat_o,
	input wire logic                      wb_ack_o,
	// pins
	input wire logic [31:0]               pio_o,
	input wire logic [31:0]               pio_oe_o
);
	import plb_pkg::*;
	// ------------------------------
	// shadow of run flag and last read
	// ------------------------------
	logic        take;
	logic        run_q, run_d, ctl_q, ctl_d;
	logic [1:0]  stp_q, stp_d;
	logic [31:0] msk_q, msk_d;
	assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// updated at the request edge, the same edge the slave writes on
	always_comb begin
		run_d = run_q;
		ctl_d = ctl_q;
		msk_d = msk_q;
		stp_d = run_q ? 2'h0 : stp_q + {1'b0, stp_q != 2'h3};
		if (take) begin
			ctl_d = ~wb_we_i & (wb_adr_i[11:2] == 10'h300);
			case (wb_adr_i[11:10])
			REG_TERM: msk_d = 32'h003F_FFFF;
			REG_ROUTE: msk_d = 32'h0000_007F;
			REG_MCELL: msk_d = 32'h0000_07FF;
			default: msk_d = 32'h00FF_FFFF;
			endcase
			if (wb_we_i) msk_d = 32'hFFFF_FFFF;
			if (wb_we_i && wb_adr_i[11:2] == 10'h300 && wb_sel_i[0])
				run_d = wb_dat_i[0];
		end
	end
	// shadow registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_q <= 1'b0;
			ctl_q <= 1'b0;
			stp_q <= 2'h0;
			msk_q <= 32'hFFFF_FFFF;
		end else begin
			run_q <= run_d;
			ctl_q <= ctl_d;
			stp_q <= stp_d;
			msk_q <= msk_d;
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ------------------------------
	// bus and pin properties
	// ------------------------------
	a_ack_next: assert property (take |=> wb_ack_o)
		else $error("no ack one cycle after a request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(take))
		else $error("ack without a request");
	a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_read_width: assert property (wb_ack_o |-> (wb_dat_o & ~msk_q) == 32'h0)
		else $error("read data wider than its register");
	a_ctrl_read: assert property (
		wb_ack_o && ctl_q |-> wb_dat_o == {31'h0, run_q})
		else $error("control read differs from last write");
	a_reset_quiet: assert property (
		$fell(rst_i) |-> pio_oe_o == 32'h0 && pio_o == 32'h0)
		else $error("pins active after reset");
	a_stop_float: assert property (stp_q == 2'h3 |-> pio_oe_o == 32'h0)
		else $error("pin driven while stopped");
	a_stop_soon: assert property ($fell(run_q) |-> ##[1:2] pio_oe_o == 32'h0)
		else $error("pins still driven after stop");
endmodule : plb_top_sva
bind plb_top plb_top_sva chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.pio_o, .pio_oe_o);
`default_nettype wire

// ### testbench/plb_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module plb_top_tb_top;
	import plb_pkg::*;
	// ------------------------------
	// bench signals
	// ------------------------------
	logic             clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic             wb_cyc_i = 1'b0;
	logic             wb_stb_i = 1'b0;
	logic             wb_we_i = 1'b0;
	logic [ADR_W-1:0] wb_adr_i = '0;
	logic [3:0]       wb_sel_i = 4'hF;
	logic [31:0]      wb_dat_i = '0;
	logic [31:0]      wb_dat_o;
	logic             wb_ack_o;
	logic [3:0]       din_i = '0;
	logic [3:0]       din_drv = 4'hF;
	logic [1:0]       clock_or_input_pin_i = '0;
	logic [31:0]      pio_i, pio_drv_i, pio_o, pio_oe_o;
	logic [31:0]      want = '0, wdrv = '0, q;
	logic             e, v, kv;
	int               n_fail = 0, checked = 0, t, p, k;
	int               seed = 32'hF2C71A93;
	// 40 MHz clock
	always #12.5 clk_i = ~clk_i;
	plb_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.din_i, .din_drv_i(din_drv), .clock_or_input_pin_i,
		.clock_or_input_pin_drv_i(2'h3), .pio_i, .pio_drv_i, .pio_o,
		.pio_oe_o);
	plb_board board_u (.clk_i, .want_i(want), .want_drv_i(wdrv),
		.dev_i(pio_o), .dev_oe_i(pio_oe_o), .lvl_o(pio_i),
		.drv_o(pio_drv_i));
	// ------------------------------
	// tasks
	// ------------------------------
	task automatic end_sim;
		$display("compares %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	// one classic cycle on block 0; held until ack is sampled
	task automatic wb(input logic w, input logic [1:0] r, input int x,
		input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {2'h0, r, x[7:0], 2'h0};
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 16);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			n_fail++;
			end_sim();
		end
	endtask : wb
	// config is taken only while stopped
	task automatic setmc(input int m, input logic [31:0] d);
		wb(1'b1, REG_GLOB, 0, 32'h0);
		wb(1'b1, REG_MCELL, m, d);
		wb(1'b1, REG_GLOB, 0, 32'h1);
	endtask : setmc
	// literals: 0 din0, 1 pin 9, 2 din1, 3 din2; unused terms made false
	function automatic logic [31:0] lit(input int n, input bit c);
		case (n)
		0, 64: return c ? 32'h0 : 32'h1;
		4, 12: return c ? 32'h0 : 32'h2;
		66: return c ? 32'h0 : 32'h4;
		67: return c ? 32'h0 : 32'h8;
		default: return 32'h1;
		endcase
	endfunction : lit
	// a hang ends the run with a mismatch
	initial begin
		repeat (100000) @(posedge clk_i);
		n_fail++;
		end_sim();
	end
	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(pio_oe_o, 32'h0);
		wb(1'b0, REG_GLOB, 0, 32'h0);
		chk(q, CTRL_RST);
		wb(1'b0, REG_ROUTE, 30, 32'h0);
		chk(q, 32'h0);
		$display("test reset done");
		wb(1'b1, REG_ROUTE, 0, 32'h0);
		wb(1'b1, REG_ROUTE, 1, 32'hF);
		wb(1'b1, REG_ROUTE, 2, 32'h1);
		wb(1'b1, REG_ROUTE, 3, 32'h2);
		for (k = 0; k < 20; k++) begin
			t = k < 16 ? k : k + 48;
			wb(1'b1, REG_TERM, 2 * t, lit(t, 1'b0));
			wb(1'b1, REG_TERM, 2 * t + 1, lit(t, 1'b1));
		end
		wb(1'b1, REG_MCELL, 2, 32'h421);
		wb(1'b1, REG_MCELL, 4, 32'h232);
		setmc(0, 32'h240);
		// a write while running must not land
		wb(1'b1, REG_MCELL, 0, 32'h0);
		wb(1'b0, REG_MCELL, 0, 32'h0);
		chk(q, 32'h240);
		wb(1'b0, REG_ROUTE, 1, 32'h0);
		chk(q, 32'hF);
		$display("test config done");
		// comb path, both polarities, enables on, off and by term
		for (p = 0; p < 2; p++) begin
			setmc(0, 32'h240 | (p << 2));
			for (k = 0; k < 20; k++) begin
				v = 1'($random(seed));
				din_i[0] <= v;
				tick(6);
				chk(32'(pio_o[0] ^ p[0]), 32'(v));
				chk(pio_oe_o, {28'h0, 2'h1, v, 1'b1});
				if (p == 0) begin
					wb(1'b0, REG_GLOB, 1, 32'h0);
					chk(32'({q[16], q[0]}), 32'({v, v}));
				end
			end
		end
		// an undriven dedicated input keeps its last level
		din_drv[0] <= 1'b0;
		din_i[0] <= ~v;
		tick(6);
		chk(32'(pio_o[0]), 32'(v ^ 1'b1));
		din_drv[0] <= 1'b1;
		$display("test comb done");
		// d then toggle register on clock pin 0; pin 9 released late
		// buried cell 1 registers pin 0, the inverted din 0
		setmc(1, 32'(MODE_INPUT));
		for (p = 0; p < 2; p++) begin
			setmc(2, 32'h421 | (p << 3));
			e = 1'b0;
			for (k = 0; k < 16; k++) begin
				v = 1'($random(seed));
				wdrv[9] <= (k < 12);
				want[9] <= v;
				din_i[0] <= v;
				if (k < 12) kv = v;
				tick(4);
				chk(32'(pio_o[1]), 32'(e));
				clock_or_input_pin_i[0] <= 1'b1;
				tick(6);
				e = p ? e ^ kv : kv;
				chk(32'(pio_o[1]), 32'(e));
				wb(1'b0, REG_GLOB, 1, 32'h0);
				chk(32'(q[1]), 32'(v ^ 1'b1));
				clock_or_input_pin_i[0] <= 1'b0;
				tick(4);
			end
		end
		$display("test register done");
		// latch on clock pin 1: open while low, holding while high
		e = kv;
		for (k = 0; k < 16; k++) begin
			t = $random(seed);
			clock_or_input_pin_i[1] <= t[1];
			tick(4);
			if (!t[1]) e = kv;
			wdrv[9] <= 1'b1;
			want[9] <= t[0];
			kv = t[0];
			tick(6);
			if (!t[1]) e = kv;
			chk(32'(pio_o[2]), 32'(e));
		end
		$display("test latch done");
		// preset then reset on all storage; comb cell untouched
		clock_or_input_pin_i[1] <= 1'b1;
		din_i[2] <= 1'b1;
		tick(6);
		// cell 0 is still inverted from the last comb pass
		chk(32'(pio_o[2:0]), {29'h0, 2'h3, ~din_i[0]});
		din_i[1] <= 1'b1;
		tick(6);
		chk(32'(pio_o[2:0]), {29'h0, 2'h0, ~din_i[0]});
		din_i[1] <= 1'b0;
		tick(6);
		chk(32'(pio_o[2:0]), {29'h0, 2'h3, ~din_i[0]});
		din_i[2] <= 1'b0;
		wb(1'b1, REG_GLOB, 0, 32'h0);
		tick(4);
		chk(pio_oe_o, 32'h0);
		$display("test async done");
		end_sim();
	end
endmodule : plb_top_tb_top
`default_nettype wire
